// ### core/lpc_defs.svh
// Constants of the LED PWM register core: offsets, fields, resets, timing
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte offsets on the serial register port)
// ----------------------------------------------------------------
`define LPC_ADDR_SHUTDOWN 8'h00
`define LPC_ADDR_DUTY_FIRST 8'h01
`define LPC_ADDR_DUTY_LAST 8'h12
`define LPC_ADDR_APPLY 8'h13
`define LPC_ADDR_SCALE_FIRST 8'h14
`define LPC_ADDR_SCALE_LAST 8'h25
`define LPC_ADDR_GLOBAL 8'h26
`define LPC_ADDR_FREQ 8'h27
`define LPC_ADDR_SOFT_RESET 8'h2f

// ----------------------------------------------------------------
// Field positions and command values
// ----------------------------------------------------------------
`define LPC_BIT_SOFT_SHUTDOWN_N 0
`define LPC_BIT_GLOBAL_OFF 0
`define LPC_BIT_FREQ_SEL 0
`define LPC_SCALE_MSB 5
`define LPC_SCALE_W 6
`define LPC_APPLY_CMD 8'h00
`define LPC_SOFT_RESET_CMD 8'h00
`define LPC_SCALE_ON_MASK 6'h3c
`define LPC_SCALE_ON_MATCH 6'h10
`define LPC_SCALE_OFF_MASK 6'h30
`define LPC_SCALE_OFF_MATCH 6'h00

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define LPC_RST_REG 8'h00
`define LPC_RST_SCALE 6'h00
`define LPC_RST_PTR 8'h00
`define LPC_NUM_CH 18
`define LPC_PWM_STEPS 256
`define LPC_PRE_W 9

// ----------------------------------------------------------------
// Timing: clock rate and the two PWM frequencies, in Hz
// ----------------------------------------------------------------
`define LPC_CLK_HZ 250000000
`define LPC_PWM_FAST_HZ 23000
`define LPC_PWM_SLOW_HZ 3450
`define LPC_STEP_CYC_FAST (`LPC_CLK_HZ / (`LPC_PWM_FAST_HZ * `LPC_PWM_STEPS))
`define LPC_STEP_CYC_SLOW (`LPC_CLK_HZ / (`LPC_PWM_SLOW_HZ * `LPC_PWM_STEPS))

`endif

// ### core/lpc_pkg.sv
// Types of the LED PWM register core
`include "lpc_defs.svh"

package lpc_pkg;

	// ----------------------------------------------------------------
	// State of the register core
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ptr;
		logic soft_shutdown_n;
		logic global_off;
		logic freq_slow;
		logic [`LPC_NUM_CH-1:0][7:0] duty_hold;
		logic [`LPC_NUM_CH-1:0][7:0] duty_act;
		logic [`LPC_NUM_CH-1:0][`LPC_SCALE_W-1:0] scale_hold;
		logic [`LPC_NUM_CH-1:0][`LPC_SCALE_W-1:0] scale_act;
		logic [`LPC_NUM_CH-1:0] outs;
		logic [`LPC_NUM_CH-1:0][1:0] scale_sel;
		logic [`LPC_NUM_CH-1:0] enabled;
		logic active;
	} lpc_core_state_t;

	// ----------------------------------------------------------------
	// State of the shared PWM timebase
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [`LPC_PRE_W-1:0] pre;
		logic [7:0] count;
	} lpc_tb_state_t;

endpackage

// ### core/lpc_pwm_timebase.sv
// Shared free-running 256-step PWM counter with selectable step rate
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.svh"

module lpc_pwm_timebase #(
	parameter int unsigned FAST_CYC = `LPC_STEP_CYC_FAST,
	parameter int unsigned SLOW_CYC = `LPC_STEP_CYC_SLOW
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic slow_sel,
	output logic [7:0] pwm_count
);

	lpc_pkg::lpc_tb_state_t s_q;
	lpc_pkg::lpc_tb_state_t s_d;
	logic [`LPC_PRE_W-1:0] limit;

	// ----------------------------------------------------------------
	// Prescaler makes a one-cycle step enable, counter wraps at 256
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		limit = slow_sel ? `LPC_PRE_W'(SLOW_CYC - 1) : `LPC_PRE_W'(FAST_CYC - 1);
		// Compare with >= so a switch to the fast rate never overruns
		if (s_q.pre >= limit) begin
			s_d.pre = '0;
			s_d.count = s_q.count + 8'h01;
		end else begin
			s_d.pre = s_q.pre + `LPC_PRE_W'(1);
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pwm_count = s_q.count;

endmodule // lpc_pwm_timebase
`default_nettype wire

// ### core/lpc_core.sv
// LED PWM register core: write-only register set and 18-channel PWM outputs
//
// Function
// - Pointer advances by one per data byte
// - Shutdown register at 00h, bit 0
// - Shutdown bit 0 turns all channels off
// - Low shutdown pin holds outputs off
// - Eighteen duty registers 01h-12h, reset zero
// - Average current is duty over 256
// - Duty and scale writes only staged
// - Writing zero to 13h applies staged values
// - Eighteen 6-bit scale registers 14h-25h
// - Scale code decode; 00xxxx gives zero
// - Global control register 26h, bit 0
// - Global bit 1 turns every channel off
// - Frequency register 27h selects 23k/3.45k
// - Writing zero to 2Fh restores defaults
// - Power-up reset loads all defaults
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.svh"

module lpc_core #(
	parameter int unsigned FAST_CYC = `LPC_STEP_CYC_FAST,
	parameter int unsigned SLOW_CYC = `LPC_STEP_CYC_SLOW
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hw_shutdown_n_pin,
	input wire logic addr_byte_valid,
	input wire logic data_byte_valid,
	input wire logic [7:0] rx_byte,
	output logic [`LPC_NUM_CH-1:0] channel_outputs,
	output logic [2*`LPC_NUM_CH-1:0] current_scale_code,
	output logic [`LPC_NUM_CH-1:0] channel_enabled,
	output logic pwm_freq_sel,
	output logic soft_shutdown_n,
	output logic outputs_active
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Default contents of every map register; the pointer is kept
	function automatic lpc_pkg::lpc_core_state_t defaults(input logic [7:0] ptr);
		lpc_pkg::lpc_core_state_t d;
		logic [7:0] rst_val;
		// Literals cannot be bit-selected, so go through a variable
		rst_val = `LPC_RST_REG;
		d = '0;
		d.ptr = ptr;
		d.soft_shutdown_n = rst_val[`LPC_BIT_SOFT_SHUTDOWN_N];
		d.global_off = rst_val[`LPC_BIT_GLOBAL_OFF];
		d.freq_slow = rst_val[`LPC_BIT_FREQ_SEL];
		for (int i = 0; i < `LPC_NUM_CH; i++) begin
			d.duty_hold[i] = `LPC_RST_REG;
			d.duty_act[i] = `LPC_RST_REG;
			d.scale_hold[i] = `LPC_RST_SCALE;
			d.scale_act[i] = `LPC_RST_SCALE;
		end
		return d;
	endfunction

	// A code drives current only as 0100xx; 00xxxx and illegal codes stay dark
	function automatic logic scale_on(input logic [`LPC_SCALE_W-1:0] code);
		return (code & `LPC_SCALE_ON_MASK) == `LPC_SCALE_ON_MATCH;
	endfunction

	// Address falls inside an inclusive window
	function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
			input logic [7:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// ----------------------------------------------------------------
	// State and timebase
	// ----------------------------------------------------------------
	lpc_pkg::lpc_core_state_t s_q;
	lpc_pkg::lpc_core_state_t s_d;
	logic [7:0] pwm_count;
	logic [7:0] duty_idx;
	logic [7:0] scale_idx;
	logic run;

	// Counter shared by all channels so they switch on in step
	lpc_pwm_timebase #(
		.FAST_CYC(FAST_CYC),
		.SLOW_CYC(SLOW_CYC)
	) u_timebase (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.slow_sel(s_q.freq_slow),
		.pwm_count(pwm_count)
	);

	// ----------------------------------------------------------------
	// Register writes and output computation
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		duty_idx = s_q.ptr - `LPC_ADDR_DUTY_FIRST;
		scale_idx = s_q.ptr - `LPC_ADDR_SCALE_FIRST;

		// Address byte loads the pointer; data bytes land at the pointer
		if (addr_byte_valid) begin
			s_d.ptr = rx_byte;
		end else if (data_byte_valid) begin
			if (s_q.ptr == `LPC_ADDR_SHUTDOWN) begin
				s_d.soft_shutdown_n = rx_byte[`LPC_BIT_SOFT_SHUTDOWN_N];
			end else if (in_range(s_q.ptr, `LPC_ADDR_DUTY_FIRST, `LPC_ADDR_DUTY_LAST)) begin
				// Staged only; live duty is untouched until apply
				s_d.duty_hold[duty_idx[4:0]] = rx_byte;
			end else if (s_q.ptr == `LPC_ADDR_APPLY) begin
				// Only the documented command value applies; others are dropped
				if (rx_byte == `LPC_APPLY_CMD) begin
					s_d.duty_act = s_q.duty_hold;
					s_d.scale_act = s_q.scale_hold;
				end
			end else if (in_range(s_q.ptr, `LPC_ADDR_SCALE_FIRST, `LPC_ADDR_SCALE_LAST)) begin
				s_d.scale_hold[scale_idx[4:0]] = rx_byte[`LPC_SCALE_MSB:0];
			end else if (s_q.ptr == `LPC_ADDR_GLOBAL) begin
				s_d.global_off = rx_byte[`LPC_BIT_GLOBAL_OFF];
			end else if (s_q.ptr == `LPC_ADDR_FREQ) begin
				s_d.freq_slow = rx_byte[`LPC_BIT_FREQ_SEL];
			end else if (s_q.ptr == `LPC_ADDR_SOFT_RESET) begin
				if (rx_byte == `LPC_SOFT_RESET_CMD) begin
					s_d = defaults(s_q.ptr);
				end
			end
			// Any other address: byte accepted, nothing stored
			// Pointer wraps at FFh; bursts are not bounded by the map
			s_d.ptr = s_q.ptr + 8'h01;
		end

		// Any one of three off conditions blanks every channel
		run = s_q.soft_shutdown_n
			& hw_shutdown_n_pin
			& ~s_q.global_off;

		// Outputs use the live settings only, one cycle behind the counter
		for (int i = 0; i < `LPC_NUM_CH; i++) begin
			s_d.enabled[i] = scale_on(s_q.scale_act[i]);
			s_d.scale_sel[i] = s_q.scale_act[i][1:0];
			// On while count < duty gives duty/256 average
			s_d.outs[i] = run & scale_on(s_q.scale_act[i])
				& (pwm_count < s_q.duty_act[i]);
		end
		s_d.active = run;
	end

	// State register; reset loads the register defaults
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q <= defaults(`LPC_RST_PTR);
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign channel_outputs = s_q.outs;
	assign current_scale_code = s_q.scale_sel;
	assign channel_enabled = s_q.enabled;
	assign pwm_freq_sel = s_q.freq_slow;
	assign soft_shutdown_n = s_q.soft_shutdown_n;
	assign outputs_active = s_q.active;

endmodule // lpc_core
`default_nettype wire

// ### verification/lpc_core_monitor.sv
// Port-level assertion checker for the LED PWM register core
`timescale 1ns/1ps
`default_nettype none
module lpc_core_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hw_shutdown_n_pin,
	input wire logic addr_byte_valid,
	input wire logic data_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic [17:0] channel_outputs,
	input wire logic [35:0] current_scale_code,
	input wire logic [17:0] channel_enabled,
	input wire logic pwm_freq_sel,
	input wire logic soft_shutdown_n,
	input wire logic outputs_active
);
	// -----
	// Shadow pointer; apply or soft reset marks the live set as moving
	// -----
	logic [7:0] ptr_q;
	logic [1:0] cmd_q;
	wire logic wr = data_byte_valid & ~addr_byte_valid;
	wire logic cmd = wr & (ptr_q == 8'h13 | ptr_q == 8'h2f) & rx_byte == 8'h00;
	always_ff @(posedge core_clk) begin
		cmd_q <= rst_n ? {cmd_q[0], cmd} : 2'b00;
		ptr_q <= !rst_n ? 8'h00 : addr_byte_valid ? rx_byte : ptr_q + 8'(wr);
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_SHUTDOWN_BIT: assert property (wr && ptr_q == 8'h00 |=>
		soft_shutdown_n == $past(rx_byte[0])) else $error("shutdown bit wrong");
	AST_FREQ_BIT: assert property (wr && ptr_q == 8'h27 |=>
		pwm_freq_sel == $past(rx_byte[0])) else $error("frequency bit wrong");
	AST_SOFT_OFF: assert property (!soft_shutdown_n |=> !outputs_active)
		else $error("active during soft shutdown");
	AST_HW_OFF: assert property (!hw_shutdown_n_pin [*2] |=>
		channel_outputs == 18'h0 && !outputs_active) else $error("lit while pin low");
	AST_POWER_UP: assert property (disable iff (1'b0) !rst_n |=>
		{channel_outputs, current_scale_code, channel_enabled, pwm_freq_sel,
		soft_shutdown_n, outputs_active} == 75'h0) else $error("reset not dark");
	AST_SOFT_RESET: assert property (cmd && ptr_q == 8'h2f |=>
		!soft_shutdown_n && !pwm_freq_sel ##1 channel_enabled == 18'h0) else $error("no restore");
	AST_STAGED: assert property (wr && cmd_q == 2'b00 && ptr_q inside {[8'h01:8'h12],
		[8'h14:8'h25]} |=> $stable(channel_enabled) && $stable(current_scale_code))
		else $error("staged write reached live set");
	AST_GLOBAL_OFF: assert property (wr && ptr_q == 8'h26 && rx_byte[0] |=> ##1
		!outputs_active) else $error("active with global off");
endmodule // lpc_core_monitor
bind lpc_core lpc_core_monitor u_mon (.core_clk, .rst_n, .hw_shutdown_n_pin,
	.addr_byte_valid, .data_byte_valid, .rx_byte, .channel_outputs, .current_scale_code,
	.channel_enabled, .pwm_freq_sel, .soft_shutdown_n, .outputs_active);
`default_nettype wire

// ### verification/lpc_host_model.sv
// Byte-level host model driving the register port strobes
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model (
	input wire logic core_clk,
	output logic addr_byte_valid,
	output logic data_byte_valid,
	output logic [7:0] rx_byte
);
	// Write-only burst; gap idles between bytes for a slow host
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$], input int gap);
		@(posedge core_clk);
		addr_byte_valid <= 1'b1;
		rx_byte <= a;
		foreach (d[i]) begin
			@(posedge core_clk);
			addr_byte_valid <= 1'b0;
			data_byte_valid <= 1'b1;
			rx_byte <= d[i];
			repeat (gap) begin
				@(posedge core_clk);
				data_byte_valid <= 1'b0;
				rx_byte <= ~d[i];
			end
		end
		@(posedge core_clk);
		addr_byte_valid <= 1'b0;
		data_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte; // Idle byte inverts the bus; after a gap it repeats the last data value
	endtask
	initial begin
		addr_byte_valid = 1'b0;
		data_byte_valid = 1'b0;
		rx_byte = 8'h00;
	end
endmodule // lpc_host_model
`default_nettype wire

// ### verification/tb_led_pwm_register_core.sv
// Self-checking testbench of the LED PWM register core
`timescale 1ns/1ps
`default_nettype none
module tb_led_pwm_register_core;
	localparam int FC = 2;
	localparam int SC = 3;
	logic core_clk;
	logic rst_n;
	logic hw_shutdown_n_pin;
	logic addr_byte_valid;
	logic data_byte_valid;
	logic [7:0] rx_byte;
	logic [17:0] channel_outputs;
	logic [35:0] current_scale_code;
	logic [17:0] channel_enabled;
	logic pwm_freq_sel;
	logic soft_shutdown_n;
	logic outputs_active;
	logic [7:0] duty[18];
	logic [5:0] scl[18];
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	lpc_host_model host (.core_clk, .addr_byte_valid, .data_byte_valid, .rx_byte);
	lpc_core #(.FAST_CYC(FC), .SLOW_CYC(SC)) uut (.core_clk, .rst_n, .hw_shutdown_n_pin,
		.addr_byte_valid, .data_byte_valid, .rx_byte, .channel_outputs, .current_scale_code,
		.channel_enabled, .pwm_freq_sel, .soft_shutdown_n, .outputs_active);
	// -----
	// Checking and expectation helpers
	// -----
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			$display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	function automatic logic [17:0] f_en();
		for (int i = 0; i < 18; i++)
			f_en[i] = scl[i][5:2] == 4'h4;
	endfunction
	function automatic logic [35:0] f_code();
		for (int i = 0; i < 18; i++)
			f_code[2*i +: 2] = scl[i][1:0];
	endfunction
	// Settle past a frequency change, then count high cycles over one period
	task automatic meas(input int cps);
		int hi[18];
		logic [17:0] en;
		en = f_en();
		repeat (800) @(negedge core_clk);
		repeat (256 * cps) begin
			@(negedge core_clk);
			for (int i = 0; i < 18; i++)
				hi[i] += channel_outputs[i];
		end
		for (int i = 0; i < 18; i++)
			chk(64'(hi[i]), en[i] ? 64'(duty[i] * cps) : 64'h0);
	endtask
	task automatic finish_test();
		$display("compares=%0d mismatches=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Cycle ceiling well above the few thousand cycles the run needs
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		logic [7:0] qd[$];
		logic [7:0] qs[$];
		rst_n = 1'b0;
		hw_shutdown_n_pin = 1'b1;
		void'($urandom(32'hd91e5082));
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk({current_scale_code, channel_enabled, pwm_freq_sel, soft_shutdown_n}, 0);
		$display("defaults done");
		// Corner duties on the first channels, random elsewhere
		for (int i = 0; i < 18; i++) begin
			duty[i] = i == 0 ? 8'hff : i == 1 ? 8'h01 : 8'($urandom);
			scl[i] = i < 4 ? 6'(16 + i) : 6'($urandom_range(19, 0));
			qd.push_back(duty[i]);
			qs.push_back({2'b00, scl[i]});
		end
		host.wr(8'h01, qd, 0);
		host.wr(8'h14, qs, 0);
		host.wr(8'h13, '{8'h5a}, 0);
		repeat (3) @(negedge core_clk);
		chk(channel_enabled, 0);
		host.wr(8'h13, '{8'h00}, 1);
		host.wr(8'h00, '{8'h01}, 0);
		repeat (3) @(negedge core_clk);
		chk({current_scale_code, channel_enabled}, {f_code(), f_en()});
		chk({soft_shutdown_n, outputs_active}, 2'b11);
		for (int f = 0; f < 2; f++) begin
			host.wr(8'h27, '{8'(f)}, 0);
			repeat (3) @(negedge core_clk);
			chk(pwm_freq_sel, 64'(f));
			meas(f ? SC : FC);
		end
		$display("pwm done");
		host.wr(8'h26, '{8'h01}, 2);
		repeat (3) @(negedge core_clk);
		chk({outputs_active, channel_outputs}, 0);
		host.wr(8'h26, '{8'h00}, 0);
		hw_shutdown_n_pin <= 1'b0;
		repeat (3) @(negedge core_clk);
		chk({outputs_active, channel_outputs}, 0);
		@(posedge core_clk);
		hw_shutdown_n_pin <= 1'b1;
		host.wr(8'h28, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}, 0);
		repeat (3) @(negedge core_clk);
		chk({soft_shutdown_n, pwm_freq_sel, outputs_active, channel_enabled}, {3'b111, f_en()});
		$display("controls done");
		host.wr(8'h2f, '{8'h00}, 0);
		repeat (3) @(negedge core_clk);
		chk({soft_shutdown_n, pwm_freq_sel, current_scale_code, channel_enabled}, 0);
		$display("soft reset done");
		// Live controls set again, then a reset pulse in mid-run must clear them
		host.wr(8'h00, '{8'h01}, 0);
		host.wr(8'h27, '{8'h01}, 0);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk({soft_shutdown_n, pwm_freq_sel, outputs_active, channel_outputs}, 0);
		$display("mid-run reset done");
		finish_test();
	end
endmodule // tb_led_pwm_register_core
`default_nettype wire
